// >>> upm_top.sv
// Uplink port interface mode select: control register, strap capture, pin directions.
// Assumes straps are static around reset and core-side pin signals are on i_mclk.
`timescale 1ns/100ps
`include "upm_consts.svh"

module upm_top (
   input  wire logic                  i_mclk,
   input  wire logic                  i_rstn,
   // Serial register access
   input  wire logic                  i_spi_sck,
   input  wire logic                  i_spi_cs_n,
   input  wire logic                  i_spi_mosi,
   output logic                       o_spi_miso,
   output logic                       o_spi_miso_oe,
   // Straps
   input  wire logic                  i_role_strap_pin,
   input  wire logic [1:0]            i_interface_type_strap_pins,
   input  wire logic                  i_speed_strap_pin,
   // Two-way link pins
   input  wire logic                  i_crs_pin,
   output logic                       o_crs_pin,
   output logic                       o_crs_pin_oe,
   input  wire logic                  i_col_pin,
   output logic                       o_col_pin,
   output logic                       o_col_pin_oe,
   input  wire logic                  i_rxc_pin,
   output logic                       o_rxc_pin,
   output logic                       o_rxc_pin_oe,
   input  wire logic                  i_txc_pin,
   output logic                       o_txc_pin,
   output logic                       o_txc_pin_oe,
   // Uplink MAC side of the switch
   input  wire logic                  i_core_crs,
   input  wire logic                  i_core_col,
   input  wire logic                  i_core_rxc,
   input  wire logic                  i_core_txc,
   output logic                       o_core_crs,
   output logic                       o_core_col,
   output logic                       o_core_rxc,
   output logic                       o_core_txc,
   // Configuration seen by the uplink port
   output upm_pkg::upm_if_mode_t      o_if_mode,
   output upm_pkg::upm_role_t         o_role,
   output logic                       o_gigabit_speed_select,
   output logic                       o_rmii_int_clk,
   output logic                       o_rgmii_in_dly,
   output logic                       o_rgmii_out_dly,
   output logic                       o_strap_done
);
   import upm_pkg::*;

   localparam logic [2:0] SETTLE_CYC = 3'(`UPM_STRAP_SETTLE_CYC);

   // ======================================
   // Declarations
   upm_regx_if     regx ();

   upm_if_mode_t   mode_r,  mode_nxt;
   upm_role_t      role_r,  role_nxt;
   logic           speed_r, speed_nxt;
   logic           rmii_clk_r;
   logic           in_dly_r;
   logic           out_dly_r;
   logic [7:0]     reg_img;
   logic [7:0]     reg_img_r;

   upm_strap_st_t  st_r, st_nxt;
   logic [2:0]     settle_r;

   logic [3:0]     strap_sync;
   logic [3:0]     pin_sync;
   logic           wr_tog_sync;
   logic           wr_tog_prev_r;
   logic           wr_evt;
   logic           wr_hit;

   logic           phy_role;
   logic           gmii_phy;
   logic           mii_phy;
   logic           drive_crs_col;
   logic           drive_clks;
   logic           gig_capable;

   // ======================================
   // Serial register engine on its own clock
   upm_spi_slave u_spi (
      .i_sck     (i_spi_sck),
      .i_rstn    (i_rstn),
      .i_cs_n    (i_spi_cs_n),
      .i_mosi    (i_spi_mosi),
      .o_miso    (o_spi_miso),
      .o_miso_oe (o_spi_miso_oe),
      .regx      (regx.engine)
   );

   // Register image into the serial clock domain; it only moves after reset release, a
   // write or the strap load, never while a read frame is shifting out
   upm_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_rd_sync (
      .i_clk  (i_spi_sck),
      .i_rstn (i_rstn),
      .i_d    (reg_img_r),
      .o_q    (regx.rd_data)
   );

   // Write toggle into the main clock domain
   upm_sync #(.WIDTH(1), .RST_VAL(1'h0)) u_wr_sync (
      .i_clk  (i_mclk),
      .i_rstn (i_rstn),
      .i_d    (regx.wr_tog),
      .o_q    (wr_tog_sync)
   );

   // Straps are pins; pull-ups make the reset image all ones
   upm_sync #(.WIDTH(4), .RST_VAL(4'hF)) u_strap_sync (
      .i_clk  (i_mclk),
      .i_rstn (i_rstn),
      .i_d    ({i_speed_strap_pin, i_role_strap_pin, i_interface_type_strap_pins}),
      .o_q    (strap_sync)
   );

   // Link pins arriving from the far side
   upm_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_pin_sync (
      .i_clk  (i_mclk),
      .i_rstn (i_rstn),
      .i_d    ({i_txc_pin, i_rxc_pin, i_col_pin, i_crs_pin}),
      .o_q    (pin_sync)
   );

   // ======================================
   // Write decode
   assign wr_evt = wr_tog_sync ^ wr_tog_prev_r;
   assign wr_hit = wr_evt && (regx.wr_addr == `UPM_REG_ADDR);

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) wr_tog_prev_r <= 1'h0;
      else         wr_tog_prev_r <= wr_tog_sync;
   end

   // ======================================
   // Strap capture sequence
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         UPM_ST_SETTLE: if (settle_r == SETTLE_CYC) st_nxt = UPM_ST_LOAD;
         UPM_ST_LOAD:   st_nxt = UPM_ST_RUN;
         UPM_ST_RUN:    st_nxt = UPM_ST_RUN;
         default:       st_nxt = UPM_ST_RUN;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r     <= UPM_ST_SETTLE;
         settle_r <= 3'h0;
      end else begin
         st_r <= st_nxt;
         if (st_r == UPM_ST_SETTLE) settle_r <= settle_r + 3'h1;
      end
   end

   assign o_strap_done = (st_r == UPM_ST_RUN);

   // ======================================
   // Next values of the strapped fields; a software write wins
   always_comb begin
      mode_nxt  = mode_r;
      role_nxt  = role_r;
      speed_nxt = speed_r;
      if (wr_hit) begin
         mode_nxt  = upm_if_mode_t'(regx.wr_data[`UPM_MODE_HI:`UPM_MODE_LO]);
         role_nxt  = upm_role_t'(regx.wr_data[`UPM_BIT_ROLE]);
         speed_nxt = regx.wr_data[`UPM_BIT_GIG_SPEED];
      end else if (st_r == UPM_ST_LOAD) begin
         mode_nxt  = upm_if_mode_t'(strap_sync[1:0]);
         role_nxt  = upm_role_t'(strap_sync[2]);
         speed_nxt = strap_sync[3];
      end
   end

   // ======================================
   // Control register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_r     <= upm_if_mode_t'(`UPM_RST_MODE);
         role_r     <= upm_role_t'(`UPM_RST_ROLE);
         speed_r    <= `UPM_RST_GIG_SPEED;
         rmii_clk_r <= `UPM_RST_RMII_CLK;
         in_dly_r   <= `UPM_RST_RGMII_IN_DLY;
         out_dly_r  <= `UPM_RST_RGMII_OUT_DLY;
      end else begin
         mode_r  <= mode_nxt;
         role_r  <= role_nxt;
         speed_r <= speed_nxt;
         if (wr_hit) begin
            rmii_clk_r <= regx.wr_data[`UPM_BIT_RMII_CLK];
            in_dly_r   <= regx.wr_data[`UPM_BIT_RGMII_IN_DLY];
            out_dly_r  <= regx.wr_data[`UPM_BIT_RGMII_OUT_DLY];
         end
      end
   end

   // Read image; the fixed bit always reads one
   assign reg_img = {rmii_clk_r, speed_r, `UPM_RST_FIXED_ONE, in_dly_r, out_dly_r, role_r, mode_r};

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) reg_img_r <= 8'h00;
      else         reg_img_r <= reg_img;
   end

   // ======================================
   // Pin direction decode
   assign phy_role      = (role_r == UPM_ROLE_PHY);
   assign gmii_phy      = (mode_r == UPM_IF_GMII) && phy_role;
   assign mii_phy       = (mode_r == UPM_IF_MII) && phy_role;
   assign drive_crs_col = gmii_phy || mii_phy;
   assign drive_clks    = mii_phy;
   assign gig_capable   = (mode_r == UPM_IF_GMII) || (mode_r == UPM_IF_RGMII);

   // ======================================
   // Pin drivers and core-side views
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_crs_pin_oe <= 1'h0;
         o_col_pin_oe <= 1'h0;
         o_rxc_pin_oe <= 1'h0;
         o_txc_pin_oe <= 1'h0;
         o_crs_pin    <= 1'h0;
         o_col_pin    <= 1'h0;
         o_rxc_pin    <= 1'h0;
         o_txc_pin    <= 1'h0;
      end else begin
         o_crs_pin_oe <= drive_crs_col;
         o_col_pin_oe <= drive_crs_col;
         o_rxc_pin_oe <= drive_clks;
         o_txc_pin_oe <= drive_clks;
         o_crs_pin    <= drive_crs_col & i_core_crs;
         o_col_pin    <= drive_crs_col & i_core_col;
         o_rxc_pin    <= drive_clks & i_core_rxc;
         o_txc_pin    <= drive_clks & i_core_txc;
      end
   end

   // Core sees the far side only on pins that are inputs
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_core_crs <= 1'h0;
         o_core_col <= 1'h0;
         o_core_rxc <= 1'h0;
         o_core_txc <= 1'h0;
      end else begin
         o_core_crs <= ~drive_crs_col & pin_sync[0];
         o_core_col <= ~drive_crs_col & pin_sync[1];
         o_core_rxc <= ~drive_clks & pin_sync[2];
         o_core_txc <= ~drive_clks & pin_sync[3];
      end
   end

   // ======================================
   // Configuration outputs
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_if_mode              <= upm_if_mode_t'(`UPM_RST_MODE);
         o_role                 <= upm_role_t'(`UPM_RST_ROLE);
         o_gigabit_speed_select <= `UPM_RST_GIG_SPEED;
         o_rmii_int_clk         <= `UPM_RST_RMII_CLK;
         o_rgmii_in_dly         <= `UPM_RST_RGMII_IN_DLY;
         o_rgmii_out_dly        <= `UPM_RST_RGMII_OUT_DLY;
      end else begin
         o_if_mode              <= mode_r;
         o_role                 <= role_r;
         o_gigabit_speed_select <= speed_r & gig_capable;
         o_rmii_int_clk         <= rmii_clk_r;
         o_rgmii_in_dly         <= in_dly_r;
         o_rgmii_out_dly        <= out_dly_r;
      end
   end
endmodule

// >>> upm_consts.svh
// Constants for the uplink port interface mode select block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef UPM_CONSTS_SVH
`define UPM_CONSTS_SVH

// ======================================
// Register placement and field layout
`define UPM_REG_ADDR          8'h56
`define UPM_BIT_RMII_CLK      7
`define UPM_BIT_GIG_SPEED     6
`define UPM_BIT_FIXED_ONE     5
`define UPM_BIT_RGMII_IN_DLY  4
`define UPM_BIT_RGMII_OUT_DLY 3
`define UPM_BIT_ROLE          2
`define UPM_MODE_HI           1
`define UPM_MODE_LO           0

// ======================================
// Reset values (pulled-up straps read as one)
`define UPM_RST_RMII_CLK      1'h1
`define UPM_RST_GIG_SPEED     1'h1
`define UPM_RST_FIXED_ONE     1'h1
`define UPM_RST_RGMII_IN_DLY  1'h0
`define UPM_RST_RGMII_OUT_DLY 1'h1
`define UPM_RST_ROLE          1'h1
`define UPM_RST_MODE          2'h3

// ======================================
// Serial register access commands and frame layout
`define UPM_CMD_WRITE         8'h02
`define UPM_CMD_READ          8'h03
`define UPM_SPI_CMD_LAST      5'h07
`define UPM_SPI_ADDR_LAST     5'h0F
`define UPM_SPI_DATA_FIRST    5'h10
`define UPM_SPI_DATA_LAST     5'h17
`define UPM_SPI_CNT_MAX       5'h18

// ======================================
// Timing
`define UPM_MCLK_PERIOD_NS    25
`define UPM_STRAP_SETTLE_NS   100
`define UPM_STRAP_SETTLE_CYC  ((`UPM_STRAP_SETTLE_NS + `UPM_MCLK_PERIOD_NS - 1) / `UPM_MCLK_PERIOD_NS)

`endif

// >>> upm_pkg.sv
// Types for the uplink port interface mode select block.
// Assumes upm_consts.svh is reachable on the include path.
package upm_pkg;
`include "upm_consts.svh"

   // Interface type codes of the uplink port
   typedef enum logic [1:0] {
      UPM_IF_MII   = 2'h0,
      UPM_IF_RMII  = 2'h1,
      UPM_IF_GMII  = 2'h2,
      UPM_IF_RGMII = 2'h3
   } upm_if_mode_t;

   // Link role of the uplink port
   typedef enum logic {
      UPM_ROLE_PHY = 1'h0,
      UPM_ROLE_MAC = 1'h1
   } upm_role_t;

   // Strap capture sequence after reset release
   typedef enum logic [1:0] {
      UPM_ST_SETTLE = 2'h0,
      UPM_ST_LOAD   = 2'h1,
      UPM_ST_RUN    = 2'h2
   } upm_strap_st_t;
endpackage

// >>> upm_regx_if.sv
// Register exchange between the serial engine and the register core.
// Assumes the engine side runs on the serial clock and the core on i_mclk.
`timescale 1ns/100ps
interface upm_regx_if;
   logic       wr_tog;   // Toggles once per accepted write frame
   logic [7:0] wr_addr;  // Held stable from toggle until next write
   logic [7:0] wr_data;  // Held stable from toggle until next write
   logic [7:0] rd_data;  // Register image, already in serial clock domain

   modport engine (output wr_tog, output wr_addr, output wr_data, input rd_data);
   modport core   (input wr_tog, input wr_addr, input wr_data, output rd_data);
endinterface

// >>> upm_sync.sv
// Two-flop level synchroniser, any width.
// Assumes each bit is an independent level or a slowly changing word.
`timescale 1ns/100ps
module upm_sync #(
   parameter int              WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_r;

   // First flop feeds only the second
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_r <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule

// >>> upm_spi_slave.sv
// Serial register access engine, mode 0, MSB first, one data byte per frame.
// Assumes the serial clock stands still while chip select is high.
`timescale 1ns/100ps
`include "upm_consts.svh"
module upm_spi_slave (
   input  wire logic      i_sck,
   input  wire logic      i_rstn,
   input  wire logic      i_cs_n,
   input  wire logic      i_mosi,
   output logic           o_miso,
   output logic           o_miso_oe,
   upm_regx_if.engine     regx
);
   logic       frame_rstn;
   logic [4:0] cnt_r;
   logic [6:0] sh_r;
   logic [7:0] cmd_r;
   logic [7:0] addr_r;
   logic [7:0] byte_in;
   logic [7:0] rd_byte;
   logic [2:0] rd_idx;
   logic       in_data;

   // Frame state clears whenever chip select is high
   assign frame_rstn = i_rstn & ~i_cs_n;
   assign byte_in    = {sh_r, i_mosi};
   assign rd_byte    = (addr_r == `UPM_REG_ADDR) ? regx.rd_data : 8'h00;
   assign rd_idx     = 3'(`UPM_SPI_DATA_LAST - cnt_r);
   assign in_data    = (cnt_r >= `UPM_SPI_DATA_FIRST) && (cnt_r <= `UPM_SPI_DATA_LAST);
   assign o_miso_oe  = ~i_cs_n;

   // ======================================
   // Bit counter, command and address capture
   always_ff @(posedge i_sck or negedge frame_rstn) begin
      if (!frame_rstn) begin
         cnt_r  <= 5'h00;
         sh_r   <= 7'h00;
         cmd_r  <= 8'h00;
         addr_r <= 8'h00;
      end else begin
         sh_r <= byte_in[6:0];
         if (cnt_r != `UPM_SPI_CNT_MAX) cnt_r <= cnt_r + 5'h01;
         if (cnt_r == `UPM_SPI_CMD_LAST) cmd_r <= byte_in;
         if (cnt_r == `UPM_SPI_ADDR_LAST) addr_r <= byte_in;
      end
   end

   // Write capture survives the frame end for the core to pick up
   always_ff @(posedge i_sck or negedge i_rstn) begin
      if (!i_rstn) begin
         regx.wr_tog  <= 1'h0;
         regx.wr_addr <= 8'h00;
         regx.wr_data <= 8'h00;
      end else if (cnt_r == `UPM_SPI_DATA_LAST && cmd_r == `UPM_CMD_WRITE) begin
         regx.wr_addr <= addr_r;
         regx.wr_data <= byte_in;
         regx.wr_tog  <= ~regx.wr_tog;
      end
   end

   // Read data launched on falling edges, MSB first
   always_ff @(negedge i_sck or negedge frame_rstn) begin
      if (!frame_rstn) begin
         o_miso <= 1'h0;
      end else begin
         o_miso <= (in_data && cmd_r == `UPM_CMD_READ) ? rd_byte[rd_idx] : 1'h0;
      end
   end
endmodule

// >>> upm_top_properties.sv
// Concurrent checks on the ports of the uplink mode select top.
// Assumes it is bound into upm_top; every check runs on i_mclk.
`timescale 1ns/100ps
module upm_top_properties (
   input  wire logic                  i_mclk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_role_strap_pin,
   input  wire logic [1:0]            i_interface_type_strap_pins,
   input  wire logic                  i_core_crs,
   input  wire logic                  o_crs_pin,
   input  wire logic                  o_crs_pin_oe,
   input  wire logic                  o_col_pin_oe,
   input  wire logic                  o_rxc_pin,
   input  wire logic                  o_rxc_pin_oe,
   input  wire logic                  o_txc_pin_oe,
   input  wire logic                  o_core_col,
   input  wire upm_pkg::upm_if_mode_t o_if_mode,
   input  wire upm_pkg::upm_role_t    o_role,
   input  wire logic                  o_gigabit_speed_select,
   input  wire logic                  o_strap_done
);
   import upm_pkg::*;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   // ======================================
   // Expected pin directions from role and mode
   wire logic phy_w = (o_role == UPM_ROLE_PHY);
   wire logic gm_w  = phy_w && (o_if_mode == UPM_IF_GMII || o_if_mode == UPM_IF_MII);
   wire logic mii_w = phy_w && (o_if_mode == UPM_IF_MII);

   // Strap capture finishing
   sequence s_load;
      $rose(o_strap_done);
   endsequence

   // ======================================
   // Assertions
   a_crs_dir: assert property (o_crs_pin_oe == gm_w)
      else $error("carrier sense direction wrong");
   a_col_dir: assert property (o_col_pin_oe == gm_w)
      else $error("collision direction wrong");
   a_rxc_dir: assert property (o_rxc_pin_oe == mii_w)
      else $error("receive clock direction wrong");
   a_txc_dir: assert property (o_txc_pin_oe == mii_w)
      else $error("transmit clock direction wrong");
   a_speed_gate: assert property (o_gigabit_speed_select |-> o_if_mode[1])
      else $error("gigabit select outside GMII or RGMII");
   a_drive_follow: assert property (o_crs_pin_oe && $past(o_crs_pin_oe) |-> o_crs_pin == $past(i_core_crs))
      else $error("driven carrier sense does not follow core");
   a_released_low: assert property (!o_rxc_pin_oe |-> !o_rxc_pin)
      else $error("receive clock output active while released");
   a_input_blind: assert property (o_col_pin_oe && $past(o_col_pin_oe) |-> !o_core_col)
      else $error("collision seen as input while driven");
   a_strap_load: assert property (s_load |-> ##[0:2]
      (o_if_mode == i_interface_type_strap_pins && o_role == i_role_strap_pin))
      else $error("strap values not loaded");
endmodule

bind upm_top upm_top_properties chk_u (
   .i_mclk, .i_rstn, .i_role_strap_pin, .i_interface_type_strap_pins, .i_core_crs,
   .o_crs_pin, .o_crs_pin_oe, .o_col_pin_oe, .o_rxc_pin, .o_rxc_pin_oe, .o_txc_pin_oe,
   .o_core_col, .o_if_mode, .o_role, .o_gigabit_speed_select, .o_strap_done
);

// >>> upm_far_end.sv
// Far link partner: drives the four link pins whenever the device does not.
// Assumes bit order crs, col, rxc, txc on every vector.
`timescale 1ns/100ps
module upm_far_end (
   input  wire logic [3:0] i_level,
   input  wire logic [3:0] i_dev_out,
   input  wire logic [3:0] i_dev_oe,
   output logic      [3:0] o_wire
);
   // Partner lets go of each pin the device turns into an output
   assign o_wire = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_level);
endmodule

// >>> upm_top_bench.sv
// Self-checking bench for the uplink mode select top.
// Assumes upm_pkg, upm_far_end and the checker are compiled first.
`timescale 1ns/100ps
`include "upm_consts.svh"
module upm_top_bench;
   import upm_pkg::*;
   logic         i_mclk = 0, i_rstn = 0;
   logic         i_spi_sck = 0, i_spi_cs_n = 1, i_spi_mosi = 0;
   logic         i_role_strap_pin = 1, i_speed_strap_pin = 1;
   logic [1:0]   i_interface_type_strap_pins = 2'h3;
   logic         i_core_crs = 0, i_core_col = 0, i_core_rxc = 0, i_core_txc = 0;
   logic [3:0]   far_lvl = 4'h0;
   wire          i_crs_pin, i_col_pin, i_rxc_pin, i_txc_pin;
   logic         o_spi_miso, o_spi_miso_oe, o_strap_done, o_gigabit_speed_select;
   logic         o_crs_pin, o_col_pin, o_rxc_pin, o_txc_pin;
   logic         o_crs_pin_oe, o_col_pin_oe, o_rxc_pin_oe, o_txc_pin_oe;
   logic         o_core_crs, o_core_col, o_core_rxc, o_core_txc;
   logic         o_rmii_int_clk, o_rgmii_in_dly, o_rgmii_out_dly;
   upm_if_mode_t o_if_mode;
   upm_role_t    o_role;
   int           n_errors = 0, num_checks = 0, s;
   logic [7:0]   rd, d;

   // ======================================
   // Design, far partner and clock
   upm_top dut_u (
      .i_mclk, .i_rstn, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi, .o_spi_miso, .o_spi_miso_oe,
      .i_role_strap_pin, .i_interface_type_strap_pins, .i_speed_strap_pin,
      .i_crs_pin, .o_crs_pin, .o_crs_pin_oe, .i_col_pin, .o_col_pin, .o_col_pin_oe,
      .i_rxc_pin, .o_rxc_pin, .o_rxc_pin_oe, .i_txc_pin, .o_txc_pin, .o_txc_pin_oe,
      .i_core_crs, .i_core_col, .i_core_rxc, .i_core_txc,
      .o_core_crs, .o_core_col, .o_core_rxc, .o_core_txc, .o_if_mode, .o_role,
      .o_gigabit_speed_select, .o_rmii_int_clk, .o_rgmii_in_dly, .o_rgmii_out_dly, .o_strap_done
   );
   upm_far_end far_u (
      .i_level   (far_lvl),
      .i_dev_out ({o_crs_pin, o_col_pin, o_rxc_pin, o_txc_pin}),
      .i_dev_oe  ({o_crs_pin_oe, o_col_pin_oe, o_rxc_pin_oe, o_txc_pin_oe}),
      .o_wire    ({i_crs_pin, i_col_pin, i_rxc_pin, i_txc_pin})
   );
   always #12.5 i_mclk = ~i_mclk;

   // ======================================
   // Tasks
   task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic rst(input logic r, input logic [1:0] m);
      int k;
      i_rstn = 0;
      i_role_strap_pin = r;
      i_interface_type_strap_pins = m;
      tk(5);
      check("done in reset", 8'h00, {7'h0, o_strap_done});
      i_rstn = 1;
      for (k = 0; k < 20 && o_strap_done !== 1'b1; k++) tk(1);
      check("strap done", 8'h01, {7'h0, o_strap_done});
      tk(2);
   endtask
   // One serial frame; serial clock stands still outside it
   task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] w);
      logic [23:0] sh;
      int i;
      sh = {c, a, w};
      i_spi_cs_n = 0;
      #24;
      check("miso enable", 8'h01, {7'h0, o_spi_miso_oe});
      for (i = 0; i < 24; i++) begin
         i_spi_mosi = sh[23-i];
         #12 i_spi_sck = 1;
         if (i >= 16) rd = {rd[6:0], o_spi_miso};
         #24 i_spi_sck = 0;
         #12;
      end
      #24 i_spi_cs_n = 1;
      tk(12);
      check("miso release", 8'h00, {7'h0, o_spi_miso_oe});
   endtask
   // Mode, role, pin directions and speed gate against expectation
   task automatic cfg(input logic r, input logic [1:0] m, input logic sp);
      logic g;
      logic x;
      g = !r && (m == 2'h0 || m == 2'h2);
      x = !r && (m == 2'h0);
      check("mode", {6'h0, m}, {6'h0, o_if_mode});
      check("role", {7'h0, r}, {7'h0, o_role});
      check("dir", {4'h0, g, g, x, x}, {4'h0, o_crs_pin_oe, o_col_pin_oe, o_rxc_pin_oe, o_txc_pin_oe});
      check("gig", {7'h0, sp & m[1]}, {7'h0, o_gigabit_speed_select});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ======================================
   // Tests
   initial begin
      rst(1'h1, 2'h3);
      cfg(1'h1, 2'h3, 1'h1);
      check("side defaults", 8'h05, {5'h0, o_rmii_int_clk, o_rgmii_in_dly, o_rgmii_out_dly});
      xfer(`UPM_CMD_READ, `UPM_REG_ADDR, 8'h00);
      check("reset image", 8'hEF, rd);
      $display("test defaults done");
      for (s = 0; s < 8; s++) begin
         i_speed_strap_pin = s[0];
         rst(s[2], s[1:0]);
         cfg(s[2], s[1:0], s[0]);
         xfer(`UPM_CMD_READ, `UPM_REG_ADDR, 8'h00);
         check("strap image", {1'h1, s[0], 3'h5, s[2:0]}, rd);
      end
      $display("test straps done");
      for (s = 0; s < 8; s++) begin
         d = {s[1], 1'h1, 1'h0, s[0], ~s[0], s[2:0]};
         xfer(`UPM_CMD_WRITE, `UPM_REG_ADDR, d);
         cfg(s[2], s[1:0], 1'h1);
         check("side bits", {5'h0, d[7], d[4], d[3]}, {5'h0, o_rmii_int_clk, o_rgmii_in_dly, o_rgmii_out_dly});
         xfer(`UPM_CMD_READ, `UPM_REG_ADDR, 8'h00);
         check("written image", d | 8'h20, rd);
      end
      xfer(`UPM_CMD_WRITE, `UPM_REG_ADDR, 8'h02);
      cfg(1'h0, 2'h2, 1'h0);
      $display("test writes done");
      xfer(`UPM_CMD_WRITE, 8'h57, 8'hFF);
      xfer(8'h05, `UPM_REG_ADDR, 8'hFF);
      xfer(`UPM_CMD_READ, `UPM_REG_ADDR, 8'h00);
      check("kept image", 8'h22, rd);
      xfer(`UPM_CMD_READ, 8'h57, 8'h00);
      check("unmapped read", 8'h00, rd);
      $display("test refusals done");
      far_lvl = 4'h5;
      {i_core_crs, i_core_col, i_core_rxc, i_core_txc} = 4'hB;
      tk(5);
      check("phy wire", 8'h09, {4'h0, i_crs_pin, i_col_pin, i_rxc_pin, i_txc_pin});
      check("phy view", 8'h01, {4'h0, o_core_crs, o_core_col, o_core_rxc, o_core_txc});
      xfer(`UPM_CMD_WRITE, `UPM_REG_ADDR, 8'h00);
      tk(5);
      check("mii wire", 8'h0B, {4'h0, i_crs_pin, i_col_pin, i_rxc_pin, i_txc_pin});
      xfer(`UPM_CMD_WRITE, `UPM_REG_ADDR, 8'h44);
      tk(5);
      check("mac view", 8'h05, {4'h0, o_core_crs, o_core_col, o_core_rxc, o_core_txc});
      $display("test pins done");
      results();
   end

   // Watchdog well beyond the roughly 50 us the tests need
   initial begin
      #500000;
      n_errors++;
      results();
   end
endmodule
